// ==== pkg/spie_pkg.sv ====
// Constants, types and decoders for the sequencer instruction executor
package spie_pkg;

   // Clock rates and tick divider
   localparam int CLK_MHZ  = 250;
   localparam int SEQ_MHZ  = 8;
   localparam int TICK_DIV = CLK_MHZ / SEQ_MHZ;
   localparam int TICK_W   = 5;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);

   // Exact opcodes
   localparam logic [7:0] OP_DEC_AUX  = 8'hbf;
   localparam logic [7:0] OP_DEC_WID  = 8'hbe;
   localparam logic [7:0] OP_INC_WID  = 8'hbd;
   localparam logic [7:0] OP_RAND     = 8'hbc;
   localparam logic [7:0] OP_WAIT_REGISTER_OVERFLOWS    = 8'hbb;
   localparam logic [7:0] OP_LABEL    = 8'hba;
   localparam logic [7:0] OP_INT      = 8'hb9;
   localparam logic [7:0] OP_WAIT_TIMER_COMPARE   = 8'hb8;
   // Opcode group prefixes
   localparam logic [4:0] PFX_SATINC  = 5'h16;
   localparam logic [3:0] PFX_RPT     = 4'ha;
   localparam logic [2:0] PFX_WAITW   = 3'h4;
   // Field positions
   localparam int NEG_BIT  = 3;
   localparam int COND_HI  = 2;
   localparam int SKIP_HI  = 6;
   localparam int SKIP_LO  = 4;
   localparam int WCNT_HI  = 4;
   localparam int LIM_HI   = 2;
   localparam logic [5:0] WAITW_ZERO = 6'h20;
   localparam logic [3:0] RAND_MAX   = 4'h8;

   // Program memory extent
   localparam logic [4:0] PROG_LAST = 5'h17;

   // Register byte addresses
   localparam logic [4:0] A_WAIT  = 5'h00;
   localparam logic [4:0] A_WIDTH = 5'h04;
   localparam logic [4:0] A_AUX   = 5'h08;
   localparam logic [4:0] A_LIMIT = 5'h0c;
   localparam logic [4:0] A_STAT  = 5'h10;
   localparam logic [4:0] A_CTRL  = 5'h14;
   // Status and control bits
   localparam int ST_RUN  = 0;
   localparam int ST_INT  = 1;
   localparam int ST_WT   = 2;
   localparam int ST_PC   = 8;
   localparam int CT_GO   = 0;
   localparam int CT_STOP = 1;
   localparam logic [7:0] LIMIT_RST = 8'hff;

   // Executor states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_EXEC  = 5'h02,
      ST_WAIT_REGISTER_OVERFLOWS = 5'h04,
      ST_WAITW = 5'h08,
      ST_WEVT  = 5'h10
   } spie_state_t;

   // Group decoders
   function automatic logic is_skip(input logic [7:0] op);
      return ~op[7];
   endfunction
   function automatic logic is_rpt(input logic [7:0] op);
      return op[7:4] == PFX_RPT;
   endfunction
   function automatic logic is_waitw(input logic [7:0] op);
      return op[7:5] == PFX_WAITW;
   endfunction
   function automatic logic is_satinc(input logic [7:0] op);
      return op[7:3] == PFX_SATINC;
   endfunction

endpackage

// ==== pkg/spie_arith_if.sv ====
// Carrier for data register arithmetic between executor and ALU
`timescale 1ns/100ps
interface spie_arith_if;
   logic [7:0] op;    // Current opcode
   logic [7:0] x;     // Wait count in
   logic [7:0] y;     // Width index in
   logic [7:0] z;     // Aux counter in
   logic [7:0] rnd;   // Held random value
   logic [7:0] nx;    // Wait count out
   logic [7:0] ny;    // Width index out
   logic [7:0] nz;    // Aux counter out
   modport calc (input op, x, y, z, rnd, output nx, ny, nz);
   modport user (output op, x, y, z, rnd, input nx, ny, nz);
endinterface

// ==== verilog/spie_tick.sv ====
// Divider making the sequencer execution tick
`timescale 1ns/100ps
module spie_tick
   import spie_pkg::*;
(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rstn,
   // Tick out
   output logic      o_tick
);
   typedef struct packed {
      logic [TICK_W-1:0] cnt;  // Cycle count within period
      logic              tick; // One-cycle tick
   } spie_tick_t;

   spie_tick_t s;
   spie_tick_t next_s;

   // Count to the period end and pulse
   always_comb begin
      next_s = s;
      next_s.tick = (s.cnt == TICK_LAST);
      if (s.cnt == TICK_LAST) begin
         next_s.cnt = '0;
      end else begin
         next_s.cnt = s.cnt + 1'b1;
      end
      if (!i_rstn) begin
         next_s = '0;
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      s <= next_s;
   end

   assign o_tick = s.tick;
endmodule

// ==== verilog/spie_arith.sv ====
// Data register arithmetic for counter and random instructions
`timescale 1ns/100ps
module spie_arith
   import spie_pkg::*;
(
   // Operands and results
   spie_arith_if.calc a
);
   logic [8:0] sum;   // Widened increment
   logic [7:0] lim;   // Saturation limit
   logic [3:0] wid;   // Random bit count

   // Results for the arithmetic opcodes, others pass through
   always_comb begin
      sum  = {1'b0, a.y} + 9'h001;
      lim  = {5'h00, a.op[LIM_HI:0]};
      wid  = RAND_MAX;
      a.nx = a.x;
      a.ny = a.y;
      a.nz = a.z;
      if (a.y != 8'h00 && a.y <= {4'h0, RAND_MAX}) begin
         wid = a.y[3:0];
      end
      if (a.op == OP_DEC_AUX) begin
         a.nz = a.z - 8'h01;
      end else if (a.op == OP_DEC_WID) begin
         a.ny = a.y - 8'h01;
      end else if (a.op == OP_INC_WID) begin
         a.ny = a.y + 8'h01;
      end else if (is_satinc(a.op)) begin
         // Nine-bit sum lets 0xff saturate to the limit
         a.ny = (sum < {1'b0, lim}) ? sum[7:0] : lim;
      end else if (a.op == OP_RAND) begin
         a.nx = a.rnd & (8'hff >> (RAND_MAX - wid));
      end
   end
endmodule

// ==== verilog/spie_top.sv ====
// Sequencer instruction executor with Avalon-MM register slave
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module spie_top
   import spie_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   // Avalon-MM slave
   input  wire logic [4:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   // Program memory read
   output logic [4:0]       o_pc,
   input  wire logic [7:0]  i_instr,
   // Timer, random and condition inputs
   input  wire logic        i_mac_ovf,
   input  wire logic        i_mac_cmp,
   input  wire logic [7:0]  i_rand,
   input  wire logic [7:0]  i_cond,
   // Status out
   output logic             o_running,
   output logic             o_prog_int_flag,
   output logic             o_wait_done_flag
);
   import spie_pkg::*;

   // Whole module state
   typedef struct packed {
      spie_state_t st;       // Executor state
      logic        run;      // Running copy
      logic [4:0]  pc;       // Program counter
      logic [4:0]  label;    // Loop start
      logic        lab_ok;   // Loop start recorded
      logic [7:0]  x;        // Wait count register
      logic [7:0]  y;        // Width index register
      logic [7:0]  z;        // Aux counter register
      logic [7:0]  t;        // Overflow limit register
      logic [5:0]  wcnt;     // Immediate wait count
      logic        int_f;    // Program interrupt flag
      logic        wt_f;     // Wait done flag
      logic        ovf_p;    // Overflow seen since tick
      logic        cmp_p;    // Compare seen since tick
      logic [7:0]  rnd;      // Held random value
      logic        wreq;     // Wait request
      logic [31:0] rdata;    // Read data
   } spie_top_t;

   // Reset value of the state
   localparam spie_top_t RST_S = '{
      st:     ST_IDLE,
      run:    1'b0,
      pc:     5'h00,
      label:  5'h00,
      lab_ok: 1'b0,
      x:      8'h00,
      y:      8'h00,
      z:      8'h00,
      t:      LIMIT_RST,
      wcnt:   6'h00,
      int_f:  1'b0,
      wt_f:   1'b0,
      ovf_p:  1'b0,
      cmp_p:  1'b0,
      rnd:    8'h00,
      wreq:   1'b1,
      rdata:  32'h00000000
   };

   spie_top_t s;        // Registered state
   spie_top_t next_s;   // Next state
   logic      tick;     // Execution tick
   logic      go;       // Advance program counter
   logic [5:0] tgt;     // Advance target
   logic      cnd;      // Condition after negate
   logic [2:0] skp;     // Skip count field
   logic      int_set;  // Interrupt flag set
   logic      wt_set;   // Wait done flag set
   logic      int_clr;  // Interrupt flag clear
   logic      wt_clr;   // Wait done flag clear
   logic      req;      // Bus request present
   logic      wr_now;   // Write takes effect

   // ALU carrier
   spie_arith_if ai ();

   // Execution tick source
   spie_tick u_tick (
      .i_clk  (i_clk),
      .i_rstn (i_rstn),
      .o_tick (tick)
   );

   // Counter and random arithmetic
   spie_arith u_arith (
      .a (ai)
   );

   // Next-state logic for executor and bus slave
   always_comb begin
      next_s  = s;
      go      = 1'b0;
      tgt     = {1'b0, s.pc} + 6'h01;
      skp     = i_instr[SKIP_HI:SKIP_LO];
      cnd     = i_cond[i_instr[COND_HI:0]] ^ i_instr[NEG_BIT];
      int_set = 1'b0;
      wt_set  = 1'b0;
      int_clr = 1'b0;
      wt_clr  = 1'b0;
      req     = i_avs_read | i_avs_write;
      wr_now  = i_avs_write & ~s.wreq & i_avs_byteenable[0];
      ai.op   = i_instr;
      ai.x    = s.x;
      ai.y    = s.y;
      ai.z    = s.z;
      ai.rnd  = s.rnd;

      // Timer pulses held until the next tick consumes them
      next_s.ovf_p = (s.ovf_p & ~tick) | i_mac_ovf;
      next_s.cmp_p = (s.cmp_p & ~tick) | i_mac_cmp;

      // Random value frozen across a random load
      if (tick && !(s.st == ST_EXEC && i_instr == OP_RAND)) begin
         next_s.rnd = i_rand;
      end

      // Executor, one step per tick
      if (tick) begin
         unique case (s.st)
            ST_IDLE: begin
               // Nothing to run
               next_s.st = ST_IDLE;
            end
            ST_EXEC: begin
               // Arithmetic results, unchanged for other opcodes
               next_s.x = ai.nx;
               next_s.y = ai.ny;
               next_s.z = ai.nz;
               if (is_skip(i_instr)) begin
                  // Skip S, or hold on S of zero
                  if (cnd) begin
                     tgt = tgt + {3'h0, skp};
                  end
                  go = cnd | (skp != 3'h0);
               end else if (is_rpt(i_instr)) begin
                  // Jump back only to a recorded start
                  if (cnd && s.lab_ok) begin
                     next_s.pc = s.label;
                  end else begin
                     go = 1'b1;
                  end
               end else if (is_waitw(i_instr)) begin
                  // Field of zero means 32 overflows
                  if (i_instr[WCNT_HI:0] == 5'h00) begin
                     next_s.wcnt = WAITW_ZERO;
                  end else begin
                     next_s.wcnt = {1'b0, i_instr[WCNT_HI:0]};
                  end
                  next_s.st = ST_WAITW;
               end else if (i_instr == OP_WAIT_REGISTER_OVERFLOWS) begin
                  // Zero count proceeds at once
                  if (s.x == 8'h00) begin
                     go     = 1'b1;
                     wt_set = 1'b1;
                  end else begin
                     next_s.st = ST_WAIT_REGISTER_OVERFLOWS;
                  end
               end else if (i_instr == OP_WAIT_TIMER_COMPARE) begin
                  next_s.st = ST_WEVT;
               end else if (i_instr == OP_LABEL) begin
                  // Single start, replaced by each label
                  if (s.pc == PROG_LAST) begin
                     next_s.label = s.pc;
                  end else begin
                     next_s.label = tgt[4:0];
                  end
                  next_s.lab_ok = 1'b1;
                  go = 1'b1;
               end else if (i_instr == OP_INT) begin
                  int_set = 1'b1;
                  go      = 1'b1;
               end else begin
                  // Arithmetic, strobes and undefined codes advance
                  go = 1'b1;
               end
            end
            ST_WAIT_REGISTER_OVERFLOWS: begin
               // Count down the wait register per overflow
               if (s.ovf_p) begin
                  next_s.x = s.x - 8'h01;
                  if (s.x == 8'h01) begin
                     next_s.st = ST_EXEC;
                     go        = 1'b1;
                     wt_set    = 1'b1;
                  end
               end
            end
            ST_WAITW: begin
               // Count down the immediate wait per overflow
               if (s.ovf_p) begin
                  next_s.wcnt = s.wcnt - 6'h01;
                  if (s.wcnt == 6'h01) begin
                     next_s.st = ST_EXEC;
                     go        = 1'b1;
                     wt_set    = 1'b1;
                  end
               end
            end
            ST_WEVT: begin
               // Leave on a timer compare
               if (s.cmp_p) begin
                  next_s.st = ST_EXEC;
                  go        = 1'b1;
               end
            end
            default: begin
               // Illegal code returns to idle
               next_s.st = ST_IDLE;
            end
         endcase
      end

      // Advance, or stop past the last location
      if (go) begin
         if (tgt > {1'b0, PROG_LAST}) begin
            next_s.st = ST_IDLE;
         end else begin
            next_s.pc = tgt[4:0];
         end
      end

      // Wait request drops for one cycle per access
      next_s.wreq = 1'b1;
      if (req && s.wreq) begin
         next_s.wreq  = 1'b0;
         next_s.rdata = 32'h00000000;
         unique case (i_avs_address)
            A_WAIT:  next_s.rdata[7:0] = s.x;
            A_WIDTH: next_s.rdata[7:0] = s.y;
            A_AUX:   next_s.rdata[7:0] = s.z;
            A_LIMIT: next_s.rdata[7:0] = s.t;
            A_STAT: begin
               next_s.rdata[ST_RUN] = s.run;
               next_s.rdata[ST_INT] = s.int_f;
               next_s.rdata[ST_WT]  = s.wt_f;
               next_s.rdata[ST_PC+4:ST_PC] = s.pc;
            end
            default: begin
               // Unmapped reads as zero
               next_s.rdata = 32'h00000000;
            end
         endcase
      end

      // Host writes land after the executor update
      if (wr_now) begin
         unique case (i_avs_address)
            A_WAIT:  next_s.x = i_avs_writedata[7:0];
            A_WIDTH: next_s.y = i_avs_writedata[7:0];
            A_AUX:   next_s.z = i_avs_writedata[7:0];
            A_LIMIT: next_s.t = i_avs_writedata[7:0];
            A_STAT: begin
               // Write one to clear
               int_clr = i_avs_writedata[ST_INT];
               wt_clr  = i_avs_writedata[ST_WT];
            end
            A_CTRL: begin
               // Stop wins over start
               if (i_avs_writedata[CT_STOP]) begin
                  next_s.st     = ST_IDLE;
                  next_s.lab_ok = 1'b0;
               end else if (i_avs_writedata[CT_GO]) begin
                  next_s.st = ST_EXEC;
                  next_s.pc = 5'h00;
               end
            end
            default: begin
               // Unmapped writes are dropped
               next_s.t = next_s.t;
            end
         endcase
      end

      // Flags: a set in the clearing cycle survives
      next_s.int_f = (s.int_f & ~int_clr) | int_set;
      next_s.wt_f  = (s.wt_f & ~wt_clr) | wt_set;
      next_s.run   = (next_s.st != ST_IDLE);

      // Synchronous reset
      if (!i_rstn) begin
         next_s = RST_S;
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      s <= next_s;
   end

   // Outputs straight from the state register
   assign o_avs_readdata    = s.rdata;
   assign o_avs_waitrequest = s.wreq;
   assign o_pc              = s.pc;
   assign o_running         = s.run;
   assign o_prog_int_flag   = s.int_f;
   assign o_wait_done_flag  = s.wt_f;
endmodule

// ==== sim/spie_assertions.sv ====
// Port-level checks of the executor top: bus answer, pc pacing, flags
`timescale 1ns/100ps
module spie_assertions
   import spie_pkg::*;
(
   // Clock and reset
   input wire logic        i_clk,
   input wire logic        i_rstn,
   // Register bus
   input wire logic [4:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0]  i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   // Executor status
   input wire logic [4:0]  o_pc,
   input wire logic        o_running,
   input wire logic        o_prog_int_flag,
   input wire logic        o_wait_done_flag
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   // A taken request, then one low cycle of waitrequest
   sequence s_req;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence s_ans;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence
   property p_answer;
      s_req |=> s_ans;
   endproperty
   a_answer: assert property (p_answer)
      else $error("bus answer is not one cycle");
   // No request, no answer
   property p_quiet;
      !i_avs_read && !i_avs_write |=> o_avs_waitrequest;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("waitrequest low without request");
   // Unmapped reads return zero
   property p_unmap;
      i_avs_read && o_avs_waitrequest && i_avs_address > A_CTRL
         |=> o_avs_readdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not zero");
   // Data registers are eight bits wide
   property p_upper;
      i_avs_read && o_avs_waitrequest && i_avs_address <= A_LIMIT
         |=> o_avs_readdata[31:8] == 24'h0;
   endproperty
   a_upper: assert property (p_upper)
      else $error("data register upper bits set");
   // Program counter never leaves the store
   property p_pc_range;
      o_pc <= PROG_LAST;
   endproperty
   a_pc_range: assert property (p_pc_range)
      else $error("pc beyond last location");
   // While running, pc holds for at least eight cycles after each step
   property p_pc_rate;
      o_running && $past(o_running) && $changed(o_pc)
         |=> $stable(o_pc) [*8];
   endproperty
   a_pc_rate: assert property (p_pc_rate)
      else $error("pc stepped faster than the tick");
   // Idle executor keeps its pc
   property p_idle_pc;
      !o_running ##1 !o_running |-> $stable(o_pc);
   endproperty
   a_idle_pc: assert property (p_idle_pc)
      else $error("pc moved while idle");
   // Flags are raised only by a running program
   property p_int_src;
      $rose(o_prog_int_flag) |-> $past(o_running);
   endproperty
   a_int_src: assert property (p_int_src)
      else $error("interrupt flag set while idle");
   property p_wt_src;
      $rose(o_wait_done_flag) |-> $past(o_running);
   endproperty
   a_wt_src: assert property (p_wt_src)
      else $error("wait flag set while idle");
   // Interrupt flag holds until a clearing write lands
   property p_int_keep;
      o_prog_int_flag && !(i_avs_write && !o_avs_waitrequest &&
         i_avs_address == A_STAT && i_avs_byteenable[0] &&
         i_avs_writedata[ST_INT]) |=> o_prog_int_flag;
   endproperty
   a_int_keep: assert property (p_int_keep)
      else $error("interrupt flag lost");
endmodule

bind spie_top spie_assertions chk_u (.i_clk, .i_rstn, .i_avs_address,
   .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
   .o_avs_readdata, .o_avs_waitrequest, .o_pc, .o_running,
   .o_prog_int_flag, .o_wait_done_flag);

// ==== sim/spie_far_model.sv ====
// Far side model: program store and MAC timer event pulses
`timescale 1ns/100ps
module spie_far_model
   import spie_pkg::*;
(
   // Clock
   input  wire logic       i_clk,
   // Fetch address and timer enable
   input  wire logic [4:0] i_pc,
   input  wire logic       i_ev_on,
   // Toward the executor
   output logic [7:0]      o_instr,
   output logic            o_mac_ovf,
   output logic            o_mac_cmp
);
   logic [7:0] prog [24]; // Program store, loaded by the bench
   logic [5:0] ph;        // Timer phase, one event per 40 clocks
   int         ovf_cnt;   // Overflows issued so far

   // Combinational fetch; outside the store the fill opcode answers
   assign o_instr = (i_pc <= PROG_LAST) ? prog[i_pc] : 8'hc0;

   // Start quiet
   initial begin
      ph = 6'h0;
      ovf_cnt = 0;
      o_mac_ovf = 1'b0;
      o_mac_cmp = 1'b0;
   end

   // One-cycle pulses, spaced wider than a tick so none merge
   always @(posedge i_clk) begin
      ph <= (ph == 6'h27) ? 6'h0 : ph + 6'h1;
      o_mac_ovf <= i_ev_on && ph == 6'h27;
      o_mac_cmp <= i_ev_on && ph == 6'h27;
      if (i_ev_on && ph == 6'h27) begin
         ovf_cnt <= ovf_cnt + 1;
      end
   end
endmodule

// ==== sim/spie_top_tb.sv ====
// Self-checking bench for the sequencer instruction executor
`timescale 1ns/100ps
module spie_top_tb;
   import spie_pkg::*;
   logic        i_clk, i_rstn;          // Clock and reset
   logic [4:0]  i_avs_address;          // Bus request
   logic        i_avs_read, i_avs_write;
   logic [31:0] i_avs_writedata;
   logic [3:0]  i_avs_byteenable;
   logic [31:0] o_avs_readdata;         // Bus answer
   logic        o_avs_waitrequest;
   logic [4:0]  o_pc;                   // Fetch
   logic [7:0]  i_instr;
   logic        i_mac_ovf, i_mac_cmp;   // Timer events
   logic [7:0]  i_rand, i_cond;         // Random and conditions
   logic        o_running, o_prog_int_flag, o_wait_done_flag;
   logic        ev_on;                  // Timer events enabled
   logic [31:0] rdat;                   // Last read data
   int          n_fail, checks, k, n, d, snap;
   // Random load cases: width in, wait count out
   logic [7:0]  yv [4] = '{8'h03, 8'h00, 8'h09, 8'h05};
   logic [7:0]  xv [4] = '{8'h06, 8'hb6, 8'hb6, 8'h16};
   // Stall cases at the last location
   logic [7:0]  s_op [5] = '{8'h80, 8'h83, 8'hbb, 8'hbb, 8'hb8};
   logic [7:0]  s_x [5] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
   int          s_n [5] = '{32, 3, 2, 0, 1};
   // Loop and skip cases: program, conditions, aux result
   logic [63:0] c_op [5] = '{64'hb9a9bfba, 64'hb9a1bf,
      64'hb9bfbf21, 64'hb9bfbf21, 64'hb9bfbf29};
   logic [7:0]  c_cd [5] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h02};
   logic [7:0]  c_z [5] = '{8'hff, 8'hff, 8'h00, 8'hfe, 8'hfe};

   spie_top dut_u (.i_clk, .i_rstn, .i_avs_address, .i_avs_read,
      .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
      .o_avs_waitrequest, .o_pc, .i_instr, .i_mac_ovf, .i_mac_cmp, .i_rand,
      .i_cond, .o_running, .o_prog_int_flag, .o_wait_done_flag);
   spie_far_model far_u (.i_clk, .i_pc(o_pc), .i_ev_on(ev_on),
      .o_instr(i_instr), .o_mac_ovf(i_mac_ovf), .o_mac_cmp(i_mac_cmp));

   // 250 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One bus access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [7:0] dt, input logic [3:0] be);
      int m;
      m = 0;
      @(posedge i_clk);
      i_avs_read <= ~wr;
      i_avs_write <= wr;
      i_avs_address <= a;
      i_avs_writedata <= {24'h0, dt};
      i_avs_byteenable <= be;
      do begin
         @(posedge i_clk);
         m++;
      end while (o_avs_waitrequest !== 1'b0 && m < 40);
      rdat = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      chk({31'h0, m < 40}, 32'h1);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h0, 4'hf);
      chk(rdat, exp);
   endtask
   // Load bytes 0..7, zero bytes and the rest take a strobe opcode
   task automatic setp(input logic [63:0] ops);
      for (int i = 0; i < 24; i++) begin
         far_u.prog[i] = (i < 8 && ops[8*i +: 8] != 8'h0) ?
            ops[8*i +: 8] : 8'he5;
      end
   endtask
   // Clear both flags, then start from location 0
   task automatic go();
      bus(1'b1, A_STAT, 8'h06, 4'h1);
      bus(1'b1, A_CTRL, 8'h01, 4'h1);
   endtask
   // Wait for the executor to go idle, bounded
   task automatic done(input int lim, output int m);
      m = 0;
      do begin
         @(posedge i_clk);
         m++;
      end while (o_running !== 1'b0 && m < lim);
      chk({31'h0, m < lim}, 32'h1);
   endtask
   task automatic close_out();
      if (n_fail == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run
   initial begin
      #400000;
      n_fail++;
      $display("FAIL %0t watchdog expired", $time);
      close_out();
   end

   // Main sequence
   initial begin
      n_fail = 0;
      checks = 0;
      {i_rstn, i_avs_read, i_avs_write, ev_on} = 4'h0;
      {i_avs_address, i_avs_writedata, i_avs_byteenable} = '0;
      i_rand = 8'hb6;
      i_cond = 8'h00;
      setp(64'h0);
      repeat (16) @(posedge i_clk);
      i_rstn <= 1'b1;
      for (k = 0; k < 5; k++) rd(5'(4*k), (k == 3) ? 32'hff : 32'h0);
      rd(5'h18, 32'h0);
      bus(1'b1, A_AUX, 8'ha5, 4'h1);
      bus(1'b1, A_AUX, 8'h5a, 4'h0);
      rd(A_AUX, 32'ha5);
      bus(1'b1, 5'h1c, 8'h77, 4'h1);
      rd(5'h1c, 32'h0);
      bus(1'b1, A_LIMIT, 8'h3c, 4'h1);
      rd(A_LIMIT, 32'h3c);
      // Counter arithmetic with wraps and saturation
      bus(1'b1, A_AUX, 8'h00, 4'h1);
      setp(64'hb4b5bdb3bebdbebf);
      go();
      done(1000, n);
      chk({31'h0, n >= 23*31 && n <= 24*31+4}, 32'h1);
      rd(A_WIDTH, 32'h04);
      rd(A_AUX, 32'hff);
      rd(A_STAT, 32'h1700);
      // Random loads of several widths
      for (k = 0; k < 4; k++) begin
         bus(1'b1, A_WIDTH, yv[k], 4'h1);
         setp(64'hbc);
         go();
         done(1000, n);
         rd(A_WAIT, {24'h0, xv[k]});
      end
      // Waits on timer events at the last location
      for (k = 0; k < 5; k++) begin
         ev_on <= 1'b0;
         bus(1'b1, A_WAIT, s_x[k], 4'h1);
         setp(64'h0);
         far_u.prog[23] = s_op[k];
         go();
         @(posedge i_clk); // Let the start land before watching pc
         for (n = 0; n < 900 && o_pc !== PROG_LAST; n++) @(posedge i_clk);
         repeat (100) @(posedge i_clk);
         chk({31'h0, o_running}, {31'h0, s_n[k] != 0});
         snap = far_u.ovf_cnt;
         ev_on <= 1'b1;
         done(1500, n);
         d = far_u.ovf_cnt - snap;
         chk({31'h0, d >= s_n[k] && d <= s_n[k] + 1}, 32'h1);
         rd(A_WAIT, 32'h0);
         chk({31'h0, o_wait_done_flag}, {31'h0, s_op[k] != 8'hb8});
         rd(A_STAT, (s_op[k] == 8'hb8) ? 32'h1700 : 32'h1704);
      end
      // Repeat loop held by a true condition, then released
      bus(1'b1, A_CTRL, 8'h02, 4'h1);
      bus(1'b1, A_AUX, 8'h00, 4'h1);
      setp(64'ha1bfba);
      i_cond <= 8'h02;
      go();
      repeat (600) @(posedge i_clk);
      chk({31'h0, o_pc < 5'h3}, 32'h1);
      i_cond <= 8'h00;
      done(1000, n);
      bus(1'b0, A_AUX, 8'h0, 4'hf);
      chk({31'h0, rdat[7:0] >= 8'he0 && rdat[7:0] <= 8'hfd}, 32'h1);
      // Repeat and skip decisions
      for (k = 0; k < 5; k++) begin
         bus(1'b1, A_CTRL, 8'h02, 4'h1);
         bus(1'b1, A_AUX, 8'h00, 4'h1);
         setp(c_op[k]);
         i_cond <= c_cd[k];
         go();
         done(1000, n);
         rd(A_AUX, {24'h0, c_z[k]});
         chk({31'h0, o_prog_int_flag}, 32'h1);
         rd(A_STAT, 32'h1702);
      end
      // Skip of zero holds until its condition turns true
      setp(64'h01);
      i_cond <= 8'h00;
      go();
      repeat (300) @(posedge i_clk);
      chk({26'h0, o_running, o_pc}, 32'h20);
      i_cond <= 8'h02;
      done(1000, n);
      // Skip past the end stops where it stands
      setp(64'h0);
      far_u.prog[22] = 8'h71;
      go();
      done(1000, n);
      rd(A_STAT, 32'h1600);
      close_out();
   end
endmodule
